// File: common/sfp_regs.svh
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ==========================================
// Pin synchroniser layout
`define SFP_SYNC_W 8
// {clk, select_n, reset_n, vpp, line3..line0}
`define SFP_SYNC_RST 8'h68
`define SFP_SY_CLK 7
`define SFP_SY_SEL 6
`define SFP_SY_RST 5
`define SFP_SY_VPP 4
`define SFP_SYNC_LAT 3'h4

// ==========================================
// Configuration byte fields
`define SFP_PAUSE_BIT 4
`define SFP_PAUSE_OFF 1'b0

// ==========================================
// Lane counts per transfer width
`define SFP_LANES_W1 4'h1
`define SFP_LANES_W2 4'h2
`define SFP_LANES_W4 4'h4

`endif

// File: common/sfp_pkg.sv
package sfp_pkg;

  // ==========================================
  // Protocol, width and power encodings
  typedef enum logic [1:0] {
    SFP_PR_SINGLE = 2'h0,
    SFP_PR_DUAL = 2'h1,
    SFP_PR_QUAD = 2'h2
  } sfp_proto_t;

  typedef enum logic [1:0] {
    SFP_W1 = 2'h0,
    SFP_W2 = 2'h1,
    SFP_W4 = 2'h2
  } sfp_width_t;

  typedef enum logic [1:0] {
    SFP_PWR_STANDBY = 2'h0,
    SFP_PWR_ACTIVE = 2'h1,
    SFP_PWR_FINISH = 2'h2,
    SFP_PWR_RESET = 2'h3
  } sfp_pwr_t;

endpackage

// File: logic/sfp_sync.sv
`timescale 1ns/1ps
module sfp_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sfp_sync_st_t;

  sfp_sync_st_t st_reg;
  sfp_sync_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Take a new level once stages two and three agree
    st_next.q = (st_reg.s2 & st_reg.s3) |
      (st_reg.q & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;

endmodule

// File: logic/sfp_pin_if.sv
`timescale 1ns/1ps
`include "sfp_regs.svh"
// Operation
// - Sample inputs on serial clock rising edges
// - Change driven data only on falling edges
// - Select high: deselected, output line floats
// - Deselected: standby unless internal cycle finishes
// - Select low: enabled, active, accepts command
// - Multi-lane fast reads drive line zero
// - Multi-lane programs take line one input
// - Dual protocol: lines zero, one always bidirectional
// - Enhanced supply forces temporary single-line protocol
// - Line two is data in quad use
// - Input buffers enabled except on driven lines
// - Quad line three disables pause and reset
// - Reset low: reset mode, outputs float
// - Pause while selected: float, ignore clock
// - Pause off by config bit or DTR
module sfp_pin_if
  import sfp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control pins
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic hw_reset_n,
  input wire logic vpp_high,
  // Data line zero
  input wire logic serial_line_zero_level,
  output logic serial_line_zero_drive,
  output logic serial_line_zero_oe,
  output logic serial_line_zero_buf_en,
  // Data line one
  input wire logic serial_line_one_level,
  output logic serial_line_one_drive,
  output logic serial_line_one_oe,
  output logic serial_line_one_buf_en,
  // Data line two
  input wire logic serial_line_two_level,
  output logic serial_line_two_drive,
  output logic serial_line_two_oe,
  output logic serial_line_two_buf_en,
  // Data line three, pause when not data
  input wire logic serial_line_three_level,
  output logic serial_line_three_drive,
  output logic serial_line_three_oe,
  output logic serial_line_three_buf_en,
  // Configuration from the device core
  input wire sfp_proto_t protocol,
  input wire sfp_width_t cmd_width,
  input wire logic [7:0] nonvolatile_config_register,
  input wire logic [7:0] volatile_enhanced_config_register,
  input wire logic dtr_detect,
  input wire logic internal_busy,
  // Byte stream to and from the core
  input wire logic xfer_tx,
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  // Status
  output sfp_pwr_t power_state,
  output logic selected
);

  typedef struct packed {
    logic armed;
    logic [2:0] warm;
    logic dtr_seen;
    logic clk_prev;
    logic sel_prev;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic tx_take;
    logic [3:0] dq_out;
    logic [3:0] dq_oe;
    sfp_pwr_t pwr;
  } sfp_state_t;

  sfp_state_t st_reg;
  sfp_state_t st_next;

  // ==========================================
  // Pin synchronisers
  logic [`SFP_SYNC_W-1:0] sy;
  logic [3:0] dq_in;

  sfp_sync #(
    .W(`SFP_SYNC_W),
    .RST_VAL(`SFP_SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw({serial_clk, select_n, hw_reset_n, vpp_high,
      serial_line_three_level, serial_line_two_level,
      serial_line_one_level, serial_line_zero_level}),
    .q(sy)
  );

  logic clk_q;
  logic sel_q;
  logic rst_q;
  logic vpp_q;
  assign clk_q = sy[`SFP_SY_CLK];
  assign sel_q = sy[`SFP_SY_SEL];
  assign rst_q = sy[`SFP_SY_RST];
  assign vpp_q = sy[`SFP_SY_VPP];
  assign dq_in = sy[3:0];

  // ==========================================
  // Edges, width and pin functions
  logic rise_ev;
  logic fall_ev;
  sfp_proto_t proto_eff;
  sfp_width_t eff_w;
  logic [3:0] lanes;
  logic quad_three;
  logic pause_en;
  logic pause_act;
  logic rst_act;

  assign rise_ev = clk_q && !st_reg.clk_prev;
  assign fall_ev = !clk_q && st_reg.clk_prev;

  // Enhanced supply drops to the single-line protocol until it goes low
  assign proto_eff = (vpp_q && protocol != SFP_PR_SINGLE) ?
    SFP_PR_SINGLE : protocol;

  always_comb begin
    case (proto_eff)
      SFP_PR_QUAD: eff_w = SFP_W4;
      SFP_PR_DUAL: eff_w = SFP_W2;
      default: eff_w = cmd_width;
    endcase
  end

  always_comb begin
    case (eff_w)
      SFP_W4: lanes = `SFP_LANES_W4;
      SFP_W2: lanes = `SFP_LANES_W2;
      default: lanes = `SFP_LANES_W1;
    endcase
  end

  assign quad_three = !sel_q && eff_w == SFP_W4;
  assign pause_en = nonvolatile_config_register[`SFP_PAUSE_BIT] !=
    `SFP_PAUSE_OFF && volatile_enhanced_config_register[`SFP_PAUSE_BIT]
    != `SFP_PAUSE_OFF && !st_reg.dtr_seen && !quad_three;
  assign pause_act = !sel_q && pause_en && !dq_in[3];
  assign rst_act = !rst_q && !quad_three;

  // ==========================================
  // Next state
  logic [7:0] sh;
  logic [2:0] cnt_n;

  always_comb begin
    st_next = st_reg;
    sh = st_reg.tx_sh;
    cnt_n = st_reg.bit_cnt + lanes[2:0];
    st_next.rx_valid = 1'b0;
    st_next.tx_take = 1'b0;
    st_next.clk_prev = clk_q;
    st_next.sel_prev = sel_q;
    // No select edge while the synchroniser flushes its reset value
    if (st_reg.warm != `SFP_SYNC_LAT) begin
      st_next.warm = st_reg.warm + 3'h1;
      st_next.sel_prev = 1'b0;
    end
    if (st_reg.sel_prev && !sel_q) begin
      st_next.armed = 1'b1;
    end
    if (rst_act) begin
      st_next.bit_cnt = 3'h0;
      st_next.dq_oe = 4'h0;
      st_next.dtr_seen = 1'b0;
      st_next.pwr = SFP_PWR_RESET;
    end else if (sel_q) begin
      st_next.dq_oe = 4'h0;
      st_next.bit_cnt = 3'h0;
      st_next.dtr_seen = 1'b0;
      st_next.pwr = internal_busy ? SFP_PWR_FINISH :
        SFP_PWR_STANDBY;
    end else begin
      st_next.pwr = SFP_PWR_ACTIVE;
      if (dtr_detect) begin
        st_next.dtr_seen = 1'b1;
      end
      if (pause_act) begin
        st_next.dq_oe = 4'h0;
      end else if (st_reg.armed) begin
        if (!xfer_tx) begin
          st_next.dq_oe = 4'h0;
          if (rise_ev) begin
            case (eff_w)
              SFP_W4: st_next.rx_sh = {st_reg.rx_sh[3:0], dq_in};
              SFP_W2: st_next.rx_sh = {st_reg.rx_sh[5:0], dq_in[1:0]};
              default: st_next.rx_sh = {st_reg.rx_sh[6:0], dq_in[0]};
            endcase
            st_next.bit_cnt = cnt_n;
            if (cnt_n == 3'h0) begin
              st_next.rx_data = st_next.rx_sh;
              st_next.rx_valid = 1'b1;
            end
          end
        end else if (fall_ev) begin
          if (st_reg.bit_cnt == 3'h0) begin
            sh = tx_data;
            st_next.tx_take = 1'b1;
          end
          case (eff_w)
            SFP_W4: begin
              st_next.dq_out = sh[7:4];
              st_next.dq_oe = 4'hF;
            end
            SFP_W2: begin
              st_next.dq_out = {2'h0, sh[7:6]};
              st_next.dq_oe = 4'h3;
            end
            default: begin
              st_next.dq_out = {2'h0, sh[7], 1'b0};
              st_next.dq_oe = 4'h2;
            end
          endcase
          st_next.tx_sh = sh << lanes;
          st_next.bit_cnt = cnt_n;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{armed: 1'b0, warm: 3'h0, dtr_seen: 1'b0, clk_prev: 1'b0,
        sel_prev: 1'b0, bit_cnt: 3'h0, rx_sh: 8'h00, tx_sh: 8'h00,
        rx_data: 8'h00, rx_valid: 1'b0, tx_take: 1'b0,
        dq_out: 4'h0, dq_oe: 4'h0, pwr: SFP_PWR_STANDBY};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Outputs
  assign serial_line_zero_drive = st_reg.dq_out[0];
  assign serial_line_one_drive = st_reg.dq_out[1];
  assign serial_line_two_drive = st_reg.dq_out[2];
  assign serial_line_three_drive = st_reg.dq_out[3];
  assign serial_line_zero_oe = st_reg.dq_oe[0];
  assign serial_line_one_oe = st_reg.dq_oe[1];
  assign serial_line_two_oe = st_reg.dq_oe[2];
  assign serial_line_three_oe = st_reg.dq_oe[3];
  assign serial_line_zero_buf_en = !st_reg.dq_oe[0];
  assign serial_line_one_buf_en = !st_reg.dq_oe[1];
  assign serial_line_two_buf_en = !st_reg.dq_oe[2];
  assign serial_line_three_buf_en = !st_reg.dq_oe[3];
  assign tx_take = st_reg.tx_take;
  assign rx_data = st_reg.rx_data;
  assign rx_valid = st_reg.rx_valid;
  assign power_state = st_reg.pwr;
  assign selected = !sel_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_rx_on_rise: assert property (
    rx_valid |-> $past(rise_ev) && !$past(xfer_tx))
    else $error("byte completed without a rising edge");

  a_drive_on_fall: assert property (
    $changed(st_reg.dq_out) |-> $past(fall_ev))
    else $error("drive changed away from a falling edge");

  a_desel_float: assert property (
    sel_q && !rst_act |=> st_reg.dq_oe == 4'h0 && !rx_valid)
    else $error("lines driven while deselected");

  a_standby_power: assert property (
    sel_q && !rst_act |=> power_state ==
      ($past(internal_busy) ? SFP_PWR_FINISH : SFP_PWR_STANDBY))
    else $error("wrong deselected power state");

  a_active_power: assert property (
    !sel_q && !rst_act |=> power_state == SFP_PWR_ACTIVE)
    else $error("selected but not active");

  a_unarmed_quiet: assert property (
    !st_reg.armed |=> !rx_valid && !tx_take)
    else $error("traffic before first select edge");

  a_rx_line_one: assert property (
    !sel_q && !rst_act && !xfer_tx |=> !serial_line_one_oe)
    else $error("line one driven while receiving");

  a_reset_float: assert property (
    rst_act |=> st_reg.dq_oe == 4'h0 && power_state == SFP_PWR_RESET)
    else $error("outputs driven in reset mode");

  a_pause_float: assert property (
    pause_act && !rst_act |=> st_reg.dq_oe == 4'h0 && !rx_valid)
    else $error("activity during pause");

  a_dtr_no_pause: assert property (
    st_reg.dtr_seen |-> !pause_act)
    else $error("pause honoured after double rate seen");

endmodule

// File: tb/sfp_host_model.sv
`timescale 1ns/1ps
module sfp_host_model (
  // Clock
  input wire logic sys_clk,
  // Device side of the lines
  input wire logic [3:0] dev_drive,
  input wire logic [3:0] dev_oe,
  // Pins
  output logic serial_clk,
  output logic select_n,
  output logic [3:0] level
);
  logic [3:0] host_val;
  logic [3:0] host_oe;
  logic pause_on;

  // ==========================================
  // Wire level, pull-up when nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level[i] = dev_oe[i] ? dev_drive[i] : (host_oe[i] ? host_val[i] : 1'b1);
    end
    if (pause_on && !dev_oe[3]) begin
      level[3] = 1'b0;
    end
  end

  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    host_val = 4'h0;
    host_oe = 4'h0;
    pause_on = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // Clock stays low around select edges
  task automatic frame(input bit on);
    tick(4);
    host_oe = 4'h0;
    select_n = ~on;
    tick(6);
  endtask

  // ==========================================
  // One byte, sampled late in the high phase
  task automatic shift(input int lanes, input bit rd, input logic [7:0] wb,
                       output logic [7:0] rb);
    logic [3:0] grp;
    logic [3:0] msk;
    rb = 8'h00;
    msk = 4'((1 << lanes) - 1);
    host_oe = rd ? 4'h0 : msk;
    for (int k = 0; k < 8; k += lanes) begin
      host_val = 4'(wb >> (8 - k - lanes));
      tick(4);
      serial_clk = 1'b1;
      tick((k + lanes == 8) ? 12 : 4);
      grp = (lanes == 1) ? {3'h0, level[1]} : (level & msk);
      rb = 8'((rb << lanes) | grp);
      serial_clk = 1'b0;
    end
  endtask
endmodule

// File: tb/serial_flash_pin_interface_test.sv
`timescale 1ns/1ps
module serial_flash_pin_interface_test;
  import sfp_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn, hw_reset_n, vpp_high, dtr_detect, internal_busy;
  logic xfer_tx, tx_take, rx_valid, selected;
  logic [7:0] nv_cfg, ve_cfg, tx_data, rx_data, last_rx, rb;
  sfp_proto_t protocol;
  sfp_width_t cmd_width;
  sfp_pwr_t power_state;
  wire serial_clk, select_n;
  wire [3:0] lvl, drv, oe, buf_en;
  int bad_count, checks_done, rx_count, tx_count, cycles, n0;

  sfp_host_model host_u (.sys_clk(sys_clk), .dev_drive(drv), .dev_oe(oe),
    .serial_clk(serial_clk), .select_n(select_n), .level(lvl));

  sfp_pin_if dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .serial_clk(serial_clk), .select_n(select_n), .hw_reset_n(hw_reset_n),
    .vpp_high(vpp_high),
    .serial_line_zero_level(lvl[0]), .serial_line_zero_drive(drv[0]),
    .serial_line_zero_oe(oe[0]), .serial_line_zero_buf_en(buf_en[0]),
    .serial_line_one_level(lvl[1]), .serial_line_one_drive(drv[1]),
    .serial_line_one_oe(oe[1]), .serial_line_one_buf_en(buf_en[1]),
    .serial_line_two_level(lvl[2]), .serial_line_two_drive(drv[2]),
    .serial_line_two_oe(oe[2]), .serial_line_two_buf_en(buf_en[2]),
    .serial_line_three_level(lvl[3]), .serial_line_three_drive(drv[3]),
    .serial_line_three_oe(oe[3]), .serial_line_three_buf_en(buf_en[3]),
    .protocol(protocol), .cmd_width(cmd_width),
    .nonvolatile_config_register(nv_cfg),
    .volatile_enhanced_config_register(ve_cfg),
    .dtr_detect(dtr_detect), .internal_busy(internal_busy),
    .xfer_tx(xfer_tx), .tx_data(tx_data), .tx_take(tx_take),
    .rx_data(rx_data), .rx_valid(rx_valid),
    .power_state(power_state), .selected(selected));

  always #25 sys_clk = ~sys_clk;

  // ==========================================
  // Received bytes and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rx_count++;
      last_rx = rx_data;
    end
    if (tx_take === 1'b1) begin
      tx_count++;
    end
    if (cycles > 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pwr(input sfp_pwr_t got, input sfp_pwr_t exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t power %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_single;
    host_u.frame(1);
    cmp_pwr(power_state, SFP_PWR_ACTIVE);
    cmp_byte({7'h00, selected}, 8'h01);
    host_u.shift(1, 0, 8'hA5, rb);
    cmp_byte(last_rx, 8'hA5);
    xfer_tx = 1'b1;
    tx_data = 8'hC6;
    host_u.shift(1, 1, 8'h00, rb);
    xfer_tx = 1'b0;
    cmp_byte(rb, 8'hC6);
    host_u.frame(0);
    cmp_byte({4'h0, oe}, 8'h00);
    cmp_byte({7'h00, selected}, 8'h00);
    cmp_pwr(power_state, SFP_PWR_STANDBY);
    internal_busy = 1'b1;
    host_u.frame(1);
    host_u.frame(0);
    cmp_pwr(power_state, SFP_PWR_FINISH);
    internal_busy = 1'b0;
    settle(4);
    cmp_pwr(power_state, SFP_PWR_STANDBY);
  endtask

  task automatic t_quad_read;
    host_u.frame(1);
    fork
      host_u.shift(1, 0, 8'h6B, rb);
      begin
        @(posedge rx_valid);
        settle(1);
        xfer_tx = 1'b1;
        cmd_width = SFP_W4;
        tx_data = 8'h3C;
      end
    join
    n0 = tx_count;
    host_u.shift(4, 1, 8'h00, rb);
    cmp_byte(rb, 8'h3C);
    cmp_byte({4'h0, buf_en}, 8'h00);
    xfer_tx = 1'b0;
    settle(3);
    cmp_byte({4'h0, buf_en}, 8'h0F);
    cmp_byte(8'(tx_count - n0), 8'h01);
    host_u.frame(0);
    cmd_width = SFP_W1;
  endtask

  task automatic t_multi;
    protocol = SFP_PR_DUAL;
    host_u.frame(1);
    host_u.shift(2, 0, 8'h96, rb);
    cmp_byte(last_rx, 8'h96);
    host_u.frame(0);
    protocol = SFP_PR_QUAD;
    vpp_high = 1'b1;
    host_u.frame(1);
    host_u.shift(1, 0, 8'h5A, rb);
    cmp_byte(last_rx, 8'h5A);
    host_u.frame(0);
    vpp_high = 1'b0;
    host_u.frame(1);
    host_u.shift(4, 0, 8'hE7, rb);
    cmp_byte(last_rx, 8'hE7);
    hw_reset_n = 1'b0;
    settle(8);
    cmp_pwr(power_state, SFP_PWR_ACTIVE);
    hw_reset_n = 1'b1;
    host_u.frame(0);
    protocol = SFP_PR_SINGLE;
  endtask

  task automatic t_pause;
    host_u.frame(1);
    n0 = rx_count;
    host_u.pause_on = 1'b1;
    host_u.shift(1, 0, 8'hFF, rb);
    host_u.pause_on = 1'b0;
    host_u.shift(1, 0, 8'hC3, rb);
    cmp_byte(last_rx, 8'hC3);
    cmp_byte(8'(rx_count - n0), 8'h01);
    nv_cfg = 8'hEF;
    host_u.pause_on = 1'b1;
    host_u.shift(1, 0, 8'h81, rb);
    cmp_byte(last_rx, 8'h81);
    nv_cfg = 8'hFF;
    ve_cfg = 8'hEF;
    host_u.shift(1, 0, 8'h24, rb);
    cmp_byte(last_rx, 8'h24);
    ve_cfg = 8'hFF;
    dtr_detect = 1'b1;
    settle(1);
    dtr_detect = 1'b0;
    host_u.shift(1, 0, 8'h42, rb);
    cmp_byte(last_rx, 8'h42);
    host_u.pause_on = 1'b0;
    host_u.frame(0);
  endtask

  task automatic t_hw_reset;
    host_u.frame(1);
    hw_reset_n = 1'b0;
    settle(8);
    cmp_pwr(power_state, SFP_PWR_RESET);
    n0 = rx_count;
    host_u.shift(1, 0, 8'h11, rb);
    cmp_byte(8'(rx_count - n0), 8'h00);
    cmp_byte({4'h0, oe}, 8'h00);
    hw_reset_n = 1'b1;
    settle(8);
    host_u.frame(0);
  endtask

  // Power-up with select already low: no falling edge, no command
  task automatic t_power_up;
    host_u.frame(1);
    resetn = 1'b0;
    settle(4);
    resetn = 1'b1;
    settle(6);
    n0 = rx_count;
    host_u.shift(1, 0, 8'h5C, rb);
    cmp_byte(8'(rx_count - n0), 8'h00);
    host_u.frame(0);
    host_u.frame(1);
    host_u.shift(1, 0, 8'h99, rb);
    cmp_byte(last_rx, 8'h99);
    host_u.frame(0);
  endtask

  initial begin
    resetn = 1'b0;
    hw_reset_n = 1'b1;
    vpp_high = 1'b0;
    dtr_detect = 1'b0;
    internal_busy = 1'b0;
    xfer_tx = 1'b0;
    tx_data = 8'h00;
    nv_cfg = 8'hFF;
    ve_cfg = 8'hFF;
    protocol = SFP_PR_SINGLE;
    cmd_width = SFP_W1;
    settle(10);
    resetn = 1'b1;
    settle(6);
    t_single();
    t_quad_read();
    t_multi();
    t_pause();
    t_hw_reset();
    t_power_up();
    report_and_stop();
  end
endmodule
